// ==== design/snp_keepalive.v ====
// Keep-alive probe timer and connection drop decision.
// Assumes a millisecond tick and an answer pulse from the stack.
`timescale 1ns/1ps
`include "snp_defs.vh"
module snp_keepalive #(
    parameter PROBE_MS = `SNP_PROBE_MS,
    parameter MIN_MS = `SNP_MIN_MS
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Timing and link state
    input wire tick_i,
    input wire conn_i,
    input wire answer_i,
    input wire [6:0] limit_min_i,
    // Events
    output wire probe_o,
    output wire drop_o
);
    reg [31:0] probe_ms_ff;
    reg [31:0] min_ms_ff;
    reg [6:0] idle_min_ff;
    reg probe_ff;
    reg drop_ff;

    assign probe_o = probe_ff;
    assign drop_o = drop_ff;

    always @(posedge clk_i) begin
        if (!rst_n_i || !conn_i || answer_i) begin
            min_ms_ff <= 32'h0;
            idle_min_ff <= 7'h0;
            drop_ff <= 1'b0;
            if (!rst_n_i || !conn_i)
                probe_ms_ff <= 32'h0;
            probe_ff <= 1'b0;
        end else begin
            probe_ff <= 1'b0;
            drop_ff <= 1'b0;
            if (tick_i) begin
                if (probe_ms_ff == PROBE_MS - 1) begin
                    probe_ms_ff <= 32'h0;
                    probe_ff <= 1'b1;
                end else begin
                    probe_ms_ff <= probe_ms_ff + 32'h1;
                end
                if (min_ms_ff == MIN_MS - 1) begin
                    min_ms_ff <= 32'h0;
                    if (idle_min_ff != 7'h7F)
                        idle_min_ff <= idle_min_ff + 7'h1;
                end else begin
                    min_ms_ff <= min_ms_ff + 32'h1;
                end
            end
            // Zero limit never drops the link
            if (limit_min_i != 7'h0 && idle_min_ff >= limit_min_i)
                drop_ff <= 1'b1;
        end
    end
endmodule

// ==== design/snp_ms_tick.v ====
// Millisecond enable divider.
// Assumes a synchronous active-low reset from the top.
`timescale 1ns/1ps
`include "snp_defs.vh"
module snp_ms_tick #(
    parameter MS_CYCLES = `SNP_MS_CYCLES
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Restart the count so a millisecond is whole
    input wire clr_i,
    output wire tick_o
);
    reg [31:0] cnt_ff;
    reg tick_ff;

    assign tick_o = tick_ff;

    always @(posedge clk_i) begin
        if (!rst_n_i || clr_i) begin
            cnt_ff <= 32'h0;
            tick_ff <= 1'b0;
        end else if (cnt_ff == MS_CYCLES - 1) begin
            cnt_ff <= 32'h0;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
            tick_ff <= 1'b0;
        end
    end
endmodule

// ==== design/snp_packer.v ====
// Serial-to-network packer: one serial port's byte buffer and release
// logic, plus keep-alive and listening-port state for its connection.
// Assumes rx bytes and config come from logic on clk_i; tx side is a
// valid/ready stream toward the network stack.
// Behaviour
// - Length zero: release on delimiter or full
// - Length 1..1024: release at that count
// - Delimiter one byte match releases buffer
// - Both delimiters: release after the pair
// - Delimiter mode still releases at 1 KB
// - Delimiter handling needs delimiter one enabled
// - Plain mode releases with delimiter kept
// - Plus-one waits one more byte
// - Plus-two waits two more bytes
// - Strip mode drops delimiters before release
// - Gap timeout zero disables gap release
// - Silence beyond gap timeout releases buffer
// - Full buffer always releases
// - Unanswered probes past limit close connection
// - Keep-alive limit zero never closes
// - After close, listen for any host
// - Listening port resets to 4001
`timescale 1ns/1ps
`include "snp_defs.vh"
module snp_packer #(
    parameter MS_CYCLES = `SNP_MS_CYCLES,
    parameter MIN_MS = `SNP_MIN_MS,
    parameter PROBE_MS = `SNP_PROBE_MS,
    parameter BUF_BYTES = `SNP_BUF_BYTES
) (
    // Clock and reset
    input wire clk_i,
    input wire resetn_i,
    // Packing configuration
    input wire [10:0] pkt_len_i,
    input wire [7:0] delim1_i,
    input wire delim1_en_i,
    input wire [7:0] delim2_i,
    input wire delim2_en_i,
    input wire [1:0] delim_proc_i,
    input wire [15:0] gap_ms_i,
    // Connection configuration, loaded on cfg_we_i
    input wire cfg_we_i,
    input wire [6:0] ka_min_i,
    input wire [15:0] port_num_i,
    // Serial byte stream in
    input wire rx_valid_i,
    input wire [7:0] rx_data_i,
    output wire rx_ready_o,
    // Network byte stream out
    output wire tx_valid_o,
    output wire [7:0] tx_data_o,
    output wire tx_last_o,
    input wire tx_ready_i,
    // Release status
    output wire rel_pulse_o,
    output wire [2:0] rel_cause_o,
    // Connection control
    input wire conn_req_i,
    input wire conn_close_i,
    input wire ka_answer_i,
    output wire ka_probe_o,
    output wire conn_drop_o,
    output wire conn_up_o,
    output wire listen_o,
    output wire [15:0] listen_port_o,
    output wire [6:0] ka_min_o
);
    localparam CW = 11;
    localparam ST_FILL = 1'b0;
    localparam ST_DRAIN = 1'b1;
    localparam [CW-1:0] FULL_CNT = BUF_BYTES[CW-1:0];

    // Reset release through two flops
    reg rst_meta_ff;
    reg rst_n_ff;
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    reg [7:0] mem [0:BUF_BYTES-1];
    reg state_ff;
    reg [CW-1:0] cnt_ff;
    reg [CW-1:0] rel_len_ff;
    reg [CW-1:0] rd_ptr_ff;
    reg [7:0] prev_ff;
    reg prev_vld_ff;
    reg [1:0] pend_ff;
    reg [16:0] gap_cnt_ff;
    reg rx_ready_ff;
    reg tx_valid_ff;
    reg [7:0] tx_data_ff;
    reg tx_last_ff;
    reg rel_pulse_ff;
    reg [2:0] rel_cause_ff;
    reg conn_up_ff;
    reg listen_ff;
    reg ka_probe_ff;
    reg conn_drop_ff;
    reg [15:0] port_ff;
    reg [6:0] ka_min_ff;

    wire accept = rx_valid_i & rx_ready_ff;
    wire gap_tick;
    wire ka_tick;
    wire ka_probe;
    wire ka_drop;

    assign rx_ready_o = rx_ready_ff;
    assign tx_valid_o = tx_valid_ff;
    assign tx_data_o = tx_data_ff;
    assign tx_last_o = tx_last_ff;
    assign rel_pulse_o = rel_pulse_ff;
    assign rel_cause_o = rel_cause_ff;
    assign conn_up_o = conn_up_ff;
    assign listen_o = listen_ff;
    assign ka_probe_o = ka_probe_ff;
    assign conn_drop_o = conn_drop_ff;
    assign listen_port_o = port_ff;
    assign ka_min_o = ka_min_ff;

    // Gap divider restarts on each byte so whole ms are counted
    snp_ms_tick #(.MS_CYCLES(MS_CYCLES)) u_gap_tick (
        .clk_i(clk_i),
        .rst_n_i(rst_n_ff),
        .clr_i(accept | (state_ff == ST_DRAIN)),
        .tick_o(gap_tick)
    );

    snp_ms_tick #(.MS_CYCLES(MS_CYCLES)) u_ka_tick (
        .clk_i(clk_i),
        .rst_n_i(rst_n_ff),
        .clr_i(1'b0),
        .tick_o(ka_tick)
    );

    snp_keepalive #(.PROBE_MS(PROBE_MS), .MIN_MS(MIN_MS)) u_ka (
        .clk_i(clk_i),
        .rst_n_i(rst_n_ff),
        .tick_i(ka_tick),
        .conn_i(conn_up_ff),
        .answer_i(ka_answer_i),
        .limit_min_i(ka_min_ff),
        .probe_o(ka_probe),
        .drop_o(ka_drop)
    );

    // Release decision for the byte being accepted
    reg len_mode;
    reg delim_on;
    reg hit;
    reg store;
    reg [CW-1:0] new_cnt;
    reg [CW-1:0] nxt_rel_len;
    reg [2:0] nxt_cause;
    reg [1:0] nxt_pend;
    reg byte_rel;
    always @* begin
        len_mode = (pkt_len_i != 11'h0);
        // Delimiters only count with length zero and delimiter one on
        delim_on = delim1_en_i & ~len_mode;
        hit = 1'b0;
        if (delim_on && pend_ff == 2'h0) begin
            if (delim2_en_i)
                hit = prev_vld_ff && prev_ff == delim1_i &&
                      rx_data_i == delim2_i;
            else
                hit = (rx_data_i == delim1_i);
        end
        store = ~(hit && delim_proc_i == `SNP_DP_STRIP);
        new_cnt = store ? cnt_ff + {{(CW-1){1'b0}}, 1'b1} : cnt_ff;
        nxt_pend = pend_ff;
        byte_rel = 1'b0;
        nxt_cause = `SNP_RC_NONE;
        nxt_rel_len = new_cnt;
        if (pend_ff != 2'h0) begin
            nxt_pend = pend_ff - 2'h1;
            if (pend_ff == 2'h1) begin
                byte_rel = 1'b1;
                nxt_cause = `SNP_RC_DELIM;
            end
        end else if (hit) begin
            case (delim_proc_i)
                `SNP_DP_NONE: begin
                    byte_rel = 1'b1;
                    nxt_cause = `SNP_RC_DELIM;
                end
                `SNP_DP_PLUS1: nxt_pend = 2'h1;
                `SNP_DP_PLUS2: nxt_pend = 2'h2;
                `SNP_DP_STRIP: begin
                    byte_rel = 1'b1;
                    nxt_cause = `SNP_RC_DELIM;
                    // First delimiter of a pair is already stored
                    if (delim2_en_i)
                        nxt_rel_len = cnt_ff - {{(CW-1){1'b0}}, 1'b1};
                end
                default: nxt_pend = 2'h0;
            endcase
        end
        if (len_mode && new_cnt == pkt_len_i) begin
            byte_rel = 1'b1;
            nxt_cause = `SNP_RC_LEN;
        end
        // Full wins in every mode, delimiters or not
        if (new_cnt == FULL_CNT) begin
            byte_rel = 1'b1;
            nxt_cause = `SNP_RC_FULL;
        end
    end

    // Silence strictly longer than the setting; zero disables
    wire gap_rel = (gap_ms_i != 16'h0) && (cnt_ff != {CW{1'b0}}) &&
                   (gap_cnt_ff > {1'b0, gap_ms_i});

    always @(posedge clk_i) begin
        if (accept && store)
            mem[cnt_ff[CW-2:0]] <= rx_data_i;
    end

    always @(posedge clk_i) begin
        if (!rst_n_ff) begin
            state_ff <= ST_FILL;
            cnt_ff <= {CW{1'b0}};
            rel_len_ff <= {CW{1'b0}};
            rd_ptr_ff <= {CW{1'b0}};
            prev_ff <= 8'h00;
            prev_vld_ff <= 1'b0;
            pend_ff <= 2'h0;
            gap_cnt_ff <= 17'h00000;
            rx_ready_ff <= 1'b0;
            tx_valid_ff <= 1'b0;
            tx_data_ff <= 8'h00;
            tx_last_ff <= 1'b0;
            rel_pulse_ff <= 1'b0;
            rel_cause_ff <= `SNP_RC_NONE;
        end else begin
            rel_pulse_ff <= 1'b0;
            case (state_ff)
                ST_FILL: begin
                    rx_ready_ff <= 1'b1;
                    if (accept) begin
                        gap_cnt_ff <= 17'h00000;
                        prev_ff <= rx_data_i;
                        prev_vld_ff <= 1'b1;
                        pend_ff <= nxt_pend;
                        cnt_ff <= new_cnt;
                        if (byte_rel) begin
                            state_ff <= ST_DRAIN;
                            rx_ready_ff <= 1'b0;
                            rel_len_ff <= nxt_rel_len;
                            rel_pulse_ff <= 1'b1;
                            rel_cause_ff <= nxt_cause;
                        end
                    end else if (gap_rel) begin
                        state_ff <= ST_DRAIN;
                        rx_ready_ff <= 1'b0;
                        rel_len_ff <= cnt_ff;
                        rel_pulse_ff <= 1'b1;
                        rel_cause_ff <= `SNP_RC_GAP;
                    end else if (gap_tick && gap_cnt_ff != 17'h1FFFF) begin
                        gap_cnt_ff <= gap_cnt_ff + 17'h00001;
                    end
                    rd_ptr_ff <= {CW{1'b0}};
                end
                ST_DRAIN: begin
                    gap_cnt_ff <= 17'h00000;
                    prev_vld_ff <= 1'b0;
                    pend_ff <= 2'h0;
                    if (!tx_valid_ff || tx_ready_i) begin
                        if (rd_ptr_ff < rel_len_ff) begin
                            tx_valid_ff <= 1'b1;
                            tx_data_ff <= mem[rd_ptr_ff[CW-2:0]];
                            tx_last_ff <= (rd_ptr_ff ==
                                rel_len_ff - {{(CW-1){1'b0}}, 1'b1});
                            rd_ptr_ff <= rd_ptr_ff +
                                {{(CW-1){1'b0}}, 1'b1};
                        end else begin
                            // Also covers an empty stripped packet
                            tx_valid_ff <= 1'b0;
                            tx_last_ff <= 1'b0;
                            cnt_ff <= {CW{1'b0}};
                            state_ff <= ST_FILL;
                            rx_ready_ff <= 1'b1;
                        end
                    end
                end
                default: state_ff <= ST_FILL;
            endcase
        end
    end

    // Connection state, keep-alive and listening port
    always @(posedge clk_i) begin
        if (!rst_n_ff) begin
            conn_up_ff <= 1'b0;
            listen_ff <= 1'b0;
            ka_probe_ff <= 1'b0;
            conn_drop_ff <= 1'b0;
            port_ff <= `SNP_PORT_DEF;
            ka_min_ff <= `SNP_KA_DEF_MIN;
        end else begin
            if (cfg_we_i) begin
                port_ff <= port_num_i;
                // Out-of-range limit is held at the maximum
                ka_min_ff <= (ka_min_i > `SNP_KA_MAX_MIN) ?
                             `SNP_KA_MAX_MIN : ka_min_i;
            end
            ka_probe_ff <= ka_probe;
            conn_drop_ff <= ka_drop & conn_up_ff;
            if (ka_drop || conn_close_i) begin
                conn_up_ff <= 1'b0;
                listen_ff <= 1'b1;
            end else if (conn_req_i && !conn_up_ff) begin
                conn_up_ff <= 1'b1;
                listen_ff <= 1'b0;
            end else begin
                listen_ff <= ~conn_up_ff;
            end
        end
    end
endmodule

// ==== include/snp_defs.vh ====
// Constants for the serial-to-network packer: sizes, timing, codes.
// Assumes a single 250 MHz clock; included by bare name.
`ifndef SNP_DEFS_VH
`define SNP_DEFS_VH

`define SNP_BUF_BYTES 1024
`define SNP_CLK_NS 4
`define SNP_MS_NS 1000000
`define SNP_MS_CYCLES (`SNP_MS_NS / `SNP_CLK_NS)
`define SNP_MIN_MS 60000
`define SNP_PROBE_MS 60000

`define SNP_KA_DEF_MIN 7'h07
`define SNP_KA_MAX_MIN 7'h63
`define SNP_PORT_DEF 16'h0FA1

`define SNP_DP_NONE 2'h0
`define SNP_DP_PLUS1 2'h1
`define SNP_DP_PLUS2 2'h2
`define SNP_DP_STRIP 2'h3

`define SNP_RC_NONE 3'h0
`define SNP_RC_LEN 3'h1
`define SNP_RC_DELIM 3'h2
`define SNP_RC_GAP 3'h3
`define SNP_RC_FULL 3'h4

`endif

// ==== tb/snp_net_sink.sv ====
// Network-side sink model: takes packed bytes off the tx stream.
// Assumes tx signals come from flops on clk_i.
`timescale 1ns/1ps
module snp_net_sink (
    // Clock
    input logic clk_i,
    // Stream from the packer
    input logic tx_valid_i,
    input logic [7:0] tx_data_i,
    input logic tx_last_i,
    // Stall every other cycle when high
    input logic slow_i,
    output logic tx_ready_o
);
    logic [7:0] q[$];
    int np;
    logic ph;

    initial begin
        np = 0;
        ph = 1'b0;
        tx_ready_o = 1'b0;
    end

    always @(posedge clk_i) begin
        if (tx_valid_i && tx_ready_o) begin
            q.push_back(tx_data_i);
            if (tx_last_i) np++;
        end
        ph <= ~ph;
        tx_ready_o <= slow_i ? ph : 1'b1;
    end
endmodule

// ==== tb/snp_packer_props.sv ====
// Checker for snp_packer: timing relations at the top ports.
// Assumes one clock domain and binding to snp_packer.
`timescale 1ns/1ps
module snp_packer_props (
    // Clock and reset
    input logic clk_i,
    input logic resetn_i,
    // Configuration
    input logic [10:0] pkt_len_i,
    input logic [7:0] delim1_i,
    input logic delim1_en_i,
    input logic delim2_en_i,
    input logic [1:0] delim_proc_i,
    input logic [15:0] gap_ms_i,
    // Streams
    input logic rx_valid_i,
    input logic [7:0] rx_data_i,
    input logic rx_ready_o,
    input logic tx_valid_o,
    input logic [7:0] tx_data_o,
    input logic tx_ready_i,
    input logic rel_pulse_o,
    input logic [2:0] rel_cause_o,
    // Connection
    input logic conn_drop_o,
    input logic conn_up_o,
    input logic listen_o,
    input logic [6:0] ka_min_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    wire hit = rx_valid_i && rx_ready_o && pkt_len_i == 11'h000
        && delim1_en_i && !delim2_en_i && rx_data_i == delim1_i;

    a_tx_data_stands: assert property (
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("tx data changed before taken");
    a_rx_drain_refused: assert property (
        tx_valid_o |-> !rx_ready_o)
        else $error("serial byte accepted while draining");
    a_len_release: assert property (
        rx_valid_i && rx_ready_o && pkt_len_i == 11'h001
        |=> rel_pulse_o && rel_cause_o == 3'h1)
        else $error("length one did not release");
    a_delim_release: assert property (
        hit && delim_proc_i == 2'h0 |=> rel_pulse_o && rel_cause_o == 3'h2)
        else $error("delimiter did not release");
    a_plus_one_wait: assert property (
        hit && delim_proc_i == 2'h1 |=> !rel_pulse_o)
        else $error("plus mode released on delimiter");
    a_rel_before_tx: assert property (
        $rose(tx_valid_o) |-> $past(rel_pulse_o))
        else $error("tx started without release");
    a_gap_zero_off: assert property (
        rel_pulse_o && gap_ms_i == 16'h0000 |-> rel_cause_o != 3'h3)
        else $error("gap release with gap disabled");
    a_drop_relisten: assert property (
        conn_drop_o |-> ##[0:1] (!conn_up_o && listen_o))
        else $error("no return to listening after drop");
    a_ka_zero_keep: assert property (
        ka_min_o == 7'h00 |-> !conn_drop_o)
        else $error("drop with keep-alive limit zero");

    c_gap: cover property (rel_pulse_o ##1 rel_cause_o == 3'h3);
    c_full: cover property (rel_pulse_o ##1 rel_cause_o == 3'h4);
    c_drop: cover property (conn_drop_o);
endmodule

bind snp_packer snp_packer_props i_snp_packer_props (.clk_i, .resetn_i,
    .pkt_len_i, .delim1_i, .delim1_en_i, .delim2_en_i, .delim_proc_i,
    .gap_ms_i, .rx_valid_i, .rx_data_i, .rx_ready_o, .tx_valid_o,
    .tx_data_o, .tx_ready_i, .rel_pulse_o, .rel_cause_o, .conn_drop_o,
    .conn_up_o, .listen_o, .ka_min_o);

// ==== tb/snp_packer_tb.sv ====
// Testbench for snp_packer: scenarios feed serial bytes and compare
// packets collected by the sink model. Short ms and minute counts.
`timescale 1ns/1ps
module snp_packer_tb;
    logic clk_i, resetn_i, delim1_en_i, delim2_en_i, cfg_we_i, slow;
    logic rx_valid_i, conn_req_i, conn_close_i, ka_answer_i;
    logic [10:0] pkt_len_i;
    logic [7:0] delim1_i, delim2_i, rx_data_i;
    logic [1:0] delim_proc_i;
    logic [15:0] gap_ms_i, port_num_i;
    logic [6:0] ka_min_i;
    wire rx_ready_o, tx_valid_o, tx_last_o, tx_ready_i, rel_pulse_o;
    wire ka_probe_o, conn_drop_o, conn_up_o, listen_o;
    wire [7:0] tx_data_o;
    wire [2:0] rel_cause_o;
    wire [15:0] listen_port_o;
    wire [6:0] ka_min_o;
    int failures, checks_done, npx, k;
    logic [7:0] e[$];

    snp_packer #(.MS_CYCLES(4), .MIN_MS(3), .PROBE_MS(2)) i_snp_packer (
        .clk_i, .resetn_i, .pkt_len_i, .delim1_i, .delim1_en_i,
        .delim2_i, .delim2_en_i, .delim_proc_i, .gap_ms_i, .cfg_we_i,
        .ka_min_i, .port_num_i, .rx_valid_i, .rx_data_i, .rx_ready_o,
        .tx_valid_o, .tx_data_o, .tx_last_o, .tx_ready_i, .rel_pulse_o,
        .rel_cause_o, .conn_req_i, .conn_close_i, .ka_answer_i,
        .ka_probe_o, .conn_drop_o, .conn_up_o, .listen_o,
        .listen_port_o, .ka_min_o);
    snp_net_sink i_snp_net_sink (.clk_i, .tx_valid_i(tx_valid_o),
        .tx_data_i(tx_data_o), .tx_last_i(tx_last_o), .slow_i(slow),
        .tx_ready_o(tx_ready_i));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Leaves valid high so back-to-back bytes need no extra edge
    task send(input logic [7:0] b, input logic keep);
        logic r;
        rx_valid_i = 1'b1;
        rx_data_i = b;
        do begin
            r = rx_ready_o;
            tick(1);
        end while (!r);
        if (keep) e.push_back(b);
    endtask
    task quiet(input int n);
        rx_valid_i = 1'b0;
        repeat (n) begin
            tick(1);
            chk(tx_valid_o, 1'b0);
        end
    endtask
    task drain(input int n);
        int j;
        rx_valid_i = 1'b0;
        npx += n;
        j = 0;
        while ((i_snp_net_sink.np < npx || tx_valid_o) && j < 3000) begin
            tick(1);
            j++;
        end
        chk(i_snp_net_sink.np, npx);
        chk(i_snp_net_sink.q.size(), e.size());
        foreach (e[i]) chk(i_snp_net_sink.q[i], e[i]);
        i_snp_net_sink.q.delete();
        e.delete();
    endtask
    task cfg(input logic [6:0] m, input logic [15:0] p);
        ka_min_i = m;
        port_num_i = p;
        cfg_we_i = 1'b1;
        tick(1);
        cfg_we_i = 1'b0;
        tick(1);
    endtask
    task open_conn;
        conn_req_i = 1'b1;
        tick(1);
        conn_req_i = 1'b0;
        tick(2);
        chk(conn_up_o, 1'b1);
    endtask

    task t_reset;
        chk(listen_port_o, 16'h0FA1);
        chk(ka_min_o, 7'h07);
        chk(listen_o, 1'b1);
    endtask
    task t_len;
        for (int l = 1; l < 4; l += 2) begin
            pkt_len_i = 11'(l);
            for (int i = 0; i < 2 * l; i++) send(8'h10 + 8'(i), 1'b1);
            drain(2);
            chk(rel_cause_o, 3'h1);
        end
        pkt_len_i = 11'h000;
    endtask
    task t_delim;
        delim1_i = 8'h0D;
        delim1_en_i = 1'b1;
        for (int m = 0; m < 4; m++) begin
            delim_proc_i = 2'(m);
            send(8'h41, 1'b1);
            send(8'h0D, m != 3);
            for (int i = 0; i < m % 3; i++) begin
                quiet(4);
                send(8'h50 + 8'(i), 1'b1);
            end
            drain(1);
            chk(rel_cause_o, 3'h2);
        end
        delim2_i = 8'h0A;
        delim2_en_i = 1'b1;
        delim_proc_i = 2'h0;
        send(8'h0D, 1'b1);
        send(8'h41, 1'b1);
        send(8'h0D, 1'b1);
        send(8'h0A, 1'b1);
        drain(1);
        delim_proc_i = 2'h3;
        send(8'h41, 1'b1);
        send(8'h0D, 1'b0);
        send(8'h0A, 1'b0);
        drain(1);
        delim2_en_i = 1'b0;
        delim1_en_i = 1'b0;
    endtask
    task t_gap;
        delim_proc_i = 2'h1;
        gap_ms_i = 16'h0002;
        send(8'h41, 1'b1);
        send(8'h0D, 1'b1);
        quiet(8);
        drain(1);
        chk(rel_cause_o, 3'h3);
        gap_ms_i = 16'h0000;
        send(8'h42, 1'b1);
        quiet(60);
    endtask
    task t_full;
        slow = 1'b1;
        delim1_i = 8'hFF;
        delim1_en_i = 1'b1;
        for (int i = 1; i < 1024; i++) send(8'(i % 200), 1'b1);
        drain(1);
        chk(rel_cause_o, 3'h4);
        slow = 1'b0;
    endtask
    task t_ka;
        cfg(7'h64, 16'h1F90);
        chk(ka_min_o, 7'h63);
        chk(listen_port_o, 16'h1F90);
        cfg(7'h01, 16'h1F90);
        open_conn();
        k = 0;
        while (!ka_probe_o && k < 100) begin
            tick(1);
            k++;
        end
        chk(k < 100, 1'b1);
        ka_answer_i = 1'b1;
        tick(1);
        ka_answer_i = 1'b0;
        k = 0;
        while (!conn_drop_o && k < 200) begin
            tick(1);
            k++;
        end
        chk(k > 8 && k < 200, 1'b1);
        tick(1);
        chk(conn_up_o, 1'b0);
        chk(listen_o, 1'b1);
        cfg(7'h00, 16'h1F90);
        open_conn();
        tick(300);
        chk(conn_up_o, 1'b1);
        conn_close_i = 1'b1;
        tick(1);
        conn_close_i = 1'b0;
        tick(1);
        chk(conn_up_o, 1'b0);
        chk(listen_o, 1'b1);
    endtask

    task end_sim;
        $display("failures=%0d checks_done=%0d", failures, checks_done);
        if (failures == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        {resetn_i, delim1_en_i, delim2_en_i, cfg_we_i, slow} = '0;
        {rx_valid_i, conn_req_i, conn_close_i, ka_answer_i} = '0;
        {pkt_len_i, delim1_i, delim2_i, rx_data_i, delim_proc_i} = '0;
        {gap_ms_i, port_num_i, ka_min_i} = '0;
        {failures, checks_done, npx} = '0;
        tick(10);
        resetn_i = 1'b1;
        tick(5);
        t_reset();
        t_len();
        t_delim();
        t_gap();
        t_full();
        t_ka();
        end_sim();
    end
    // Whole run needs well under 10000 cycles
    // Own wait loop: the shared tick task is busy in the main flow
    initial begin
        repeat (30000) @(posedge clk_i);
        failures++;
        end_sim();
    end
endmodule
